// [pkg/lccp_pkg.sv]
package lccp_pkg;
    // widths and list sizes
    localparam int DATA_W = 16;
    localparam int MADDR_W = 18;
    localparam int COUNT_W = 14;
    localparam int LIST_DEPTH = 7;
    localparam int LIST_IDX_W = 3;
    localparam int OFF_W = 13;
    localparam logic [OFF_W-1:0] SNAP_WORDS = 13'h0080;

    // register indices on the command port
    localparam logic [1:0] REG_HDR_IN = 2'h0;
    localparam logic [1:0] REG_HDR_OUT = 2'h1;
    localparam logic [1:0] REG_DATA0 = 2'h2;
    localparam logic [1:0] REG_DATA1 = 2'h3;

    // input header fields
    localparam int HI_TYPE_LSB = 0;
    localparam int HI_RX = 2;
    localparam int HI_REQ = 5;
    localparam int HI_IEI = 6;
    localparam int HI_RDY = 7;
    localparam int HI_CLEAR = 15;

    // output header fields
    localparam int HO_TYPE_LSB = 0;
    localparam int HO_RX = 2;
    localparam int HO_IEO = 6;
    localparam int HO_RDY = 7;

    // command identifiers
    localparam logic [1:0] CMD_BUF_IN = 2'h0;
    localparam logic [1:0] CMD_CTL_IN = 2'h1;
    localparam logic [1:0] CMD_BASE_IN = 2'h3;
    localparam logic [1:0] CMD_BUF_OUT = 2'h0;
    localparam logic [1:0] CMD_CTL_OUT = 2'h1;

    // second data word fields
    localparam int D1_HI_LSB = 14;
    localparam int D1_RESUME = 12;
    localparam int D1_HALF = 1;
    localparam int D1_MAINT = 0;
    localparam int D1_FATAL = 15;

    localparam logic [7:0] ERR_OVERFLOW = 8'h01;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [7:0] SEQ_INIT = 8'h00;

    typedef enum logic [2:0] {LCCP_UNINIT, LCCP_WAIT_BASE, LCCP_RUN, LCCP_DUMP, LCCP_HALT}
        lccp_state_t;
    typedef enum logic [1:0] {LCCP_D_IDLE, LCCP_D_TX, LCCP_D_RX, LCCP_D_SNAP} lccp_dma_t;

    // reflected crc-16, one word taken low byte first
    function automatic logic [15:0] crc16_word(input logic [15:0] crc, input logic [15:0] word);
        logic [15:0] c;
        c = crc ^ word;
        for (int i = 0; i < 16; i++)
        begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage

// [verilog/lccp_buflist.sv]
// ordered list of outstanding buffers for one direction
module lccp_buflist (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clr,
    input wire logic push,
    input wire logic [lccp_pkg::MADDR_W-1:0] push_addr,
    input wire logic [lccp_pkg::COUNT_W-1:0] push_count,
    input wire logic pop,
    input wire logic [lccp_pkg::LIST_IDX_W-1:0] rd_idx,
    output logic [lccp_pkg::MADDR_W-1:0] rd_addr,
    output logic [lccp_pkg::COUNT_W-1:0] rd_count,
    output logic [lccp_pkg::MADDR_W-1:0] head_addr,
    output logic [lccp_pkg::COUNT_W-1:0] head_count,
    output logic [lccp_pkg::LIST_IDX_W-1:0] level,
    output logic full
);
    logic [lccp_pkg::MADDR_W-1:0] addr_mem [lccp_pkg::LIST_DEPTH];
    logic [lccp_pkg::COUNT_W-1:0] count_mem [lccp_pkg::LIST_DEPTH];
    logic [lccp_pkg::LIST_IDX_W-1:0] wr_idx;

    // a pop in the same cycle frees the last slot for the push
    assign wr_idx = pop ? level - 3'h1 : level;
    assign full = (level == 3'(lccp_pkg::LIST_DEPTH));
    assign rd_addr = addr_mem[rd_idx];
    assign rd_count = count_mem[rd_idx];
    assign head_addr = addr_mem[0];
    assign head_count = count_mem[0];

    // occupancy
    always_ff @(posedge mclk)
    begin
        if (srst || clr)
            level <= '0;
        else if (push && !pop)
            level <= level + 3'h1;
        else if (pop && !push)
            level <= level - 3'h1;
    end

    // storage shifts toward the head on pop
    always_ff @(posedge mclk)
    begin
        if (pop)
        begin
            for (int i = 0; i < lccp_pkg::LIST_DEPTH - 1; i++)
            begin
                addr_mem[i] <= addr_mem[i+1];
                count_mem[i] <= count_mem[i+1];
            end
        end
        if (push)
        begin
            addr_mem[wr_idx] <= push_addr;
            count_mem[wr_idx] <= push_count;
        end
    end
endmodule // lccp_buflist

// [verilog/lccp_cmd_port.sv]
// Contract
// (RULE1) four 16-bit registers for host commands
// (RULE2) two header words, two data words
// (RULE3) host requests port, device grants, executes
// (RULE4) device loads registers, then flags command ready
// (RULE5) buffer data moved by 18-bit memory requests
// (RULE6) initialization clears all condition state
// (RULE7) host initializes before start and after fatal
// (RULE8) snapshot area start address, 128 words
// (RULE9) snapshot copied only on fatal error
// (RULE10) snapshot assignment is first command after init
// (RULE11) snapshot without continue starts link protocol
// (RULE12) configuration picks duplex and maintenance mode
// (RULE13) host configures link after snapshot assignment
// (RULE14) buffer assignment: direction, address, character count
// (RULE15) at most seven buffers per direction
// (RULE16) return buffer only when done
// (RULE17) report errors fatal or not; fatal halts
// (RULE18) crc-16 check, retransmit on error
// (RULE19) sequence numbers keep order, no repeats
// (RULE20) host reads snapshot, never modifies it
// (RULE21) receive only with buffer; check before acknowledging
// (RULE22) refuse eighth buffer, report non-fatal error
module lccp_cmd_port (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic dma_req,
    output logic dma_write,
    output logic [lccp_pkg::MADDR_W-1:0] dma_addr,
    output logic [15:0] dma_wdata,
    input wire logic dma_done,
    input wire logic [15:0] dma_rdata,
    output logic tx_word_valid,
    output logic [15:0] tx_word,
    output logic [7:0] tx_seq,
    output logic tx_end,
    output logic [15:0] tx_crc,
    input wire logic tx_ack,
    input wire logic tx_nak,
    output logic rx_ready,
    input wire logic rx_word_valid,
    input wire logic [15:0] rx_word,
    input wire logic rx_end,
    input wire logic [15:0] rx_crc,
    input wire logic [7:0] rx_seq,
    output logic rx_nak,
    output logic link_start,
    output logic link_half_duplex,
    output logic link_maint,
    output logic link_running,
    input wire logic link_fatal,
    input wire logic link_error,
    input wire logic [7:0] link_err_code
);
    lccp_pkg::lccp_state_t state;
    lccp_pkg::lccp_dma_t dma_st;
    logic [1:0] in_type, out_type;
    logic in_rx, in_req, in_iei, in_rdy, out_rx, out_ieo, out_rdy;
    logic [15:0] data0, data1;
    logic init_cmd, issue, post_err, post_rx, post_tx, post_any;
    logic push_tx, push_rx, overflow, rx_good;
    logic [lccp_pkg::MADDR_W-1:0] base_addr;
    logic [lccp_pkg::MADDR_W-1:0] cmd_addr, tx_rd_addr, rx_rd_addr, tx_hd_addr, rx_hd_addr;
    logic [lccp_pkg::COUNT_W-1:0] tx_rd_count, rx_rd_count, tx_hd_count, rx_hd_count;
    logic [2:0] tx_level, rx_level, tx_done, rx_done;
    logic tx_full, rx_full, tx_wait, err_pend, err_fatal;
    logic [7:0] err_code, rx_expect;
    logic [lccp_pkg::OFF_W-1:0] tx_off, tx_words, rx_off, snap_off;
    logic [15:0] tx_run_crc, rx_run_crc, snap_data;

    // byte address of a word inside a host buffer
    function automatic logic [17:0] word_addr(input logic [17:0] base,
        input logic [12:0] off);
        return base + {4'h0, off, 1'b0};
    endfunction

    // command decode from the port strobes
    assign init_cmd = reg_wr && reg_addr == lccp_pkg::REG_HDR_IN
                      && reg_wdata[lccp_pkg::HI_CLEAR]; // see RULE6
    assign issue = reg_wr && reg_addr == lccp_pkg::REG_HDR_IN && in_rdy
                   && !reg_wdata[lccp_pkg::HI_RDY] && !init_cmd; // see RULE3
    assign cmd_addr = {data1[15:lccp_pkg::D1_HI_LSB], data0}; // see RULE2
    assign push_tx = issue && in_type == lccp_pkg::CMD_BUF_IN && !in_rx
                     && state == lccp_pkg::LCCP_RUN && !tx_full; // see RULE14
    assign push_rx = issue && in_type == lccp_pkg::CMD_BUF_IN && in_rx
                     && state == lccp_pkg::LCCP_RUN && !rx_full;
    assign overflow = issue && in_type == lccp_pkg::CMD_BUF_IN
                      && state == lccp_pkg::LCCP_RUN
                      && (in_rx ? rx_full : tx_full); // see RULE22
    assign rx_good = rx_ready && rx_end && rx_run_crc == rx_crc
                     && rx_seq == rx_expect; // see RULE21

    // output command choice: errors first, then receive, then transmit returns
    always_comb
    begin
        post_any = !out_rdy && !issue && !init_cmd;
        post_err = post_any && err_pend;
        post_rx = post_any && !err_pend && rx_done != 3'h0; // see RULE16
        post_tx = post_any && !err_pend && rx_done == 3'h0 && tx_done != 3'h0;
    end

    // snapshot image: link bookkeeping in the first words, rest zero
    always_comb
    begin
        case (snap_off[1:0])
            2'h0: snap_data = {tx_seq, rx_expect};
            2'h1: snap_data = {5'h00, tx_level, 5'h00, rx_level};
            2'h2: snap_data = {err_fatal, 7'h00, err_code};
            default: snap_data = base_addr[15:0];
        endcase
        if (snap_off[lccp_pkg::OFF_W-1:2] != '0)
            snap_data = '0;
    end

    lccp_buflist u_tx_list (
        .mclk(mclk), .srst(srst), .clr(init_cmd), .push(push_tx),
        .push_addr(cmd_addr), .push_count(data1[lccp_pkg::COUNT_W-1:0]),
        .pop(post_tx), .rd_idx(tx_done), .rd_addr(tx_rd_addr), .rd_count(tx_rd_count),
        .head_addr(tx_hd_addr), .head_count(tx_hd_count), .level(tx_level), .full(tx_full)
    ); // see RULE15

    lccp_buflist u_rx_list (
        .mclk(mclk), .srst(srst), .clr(init_cmd), .push(push_rx),
        .push_addr(cmd_addr), .push_count(data1[lccp_pkg::COUNT_W-1:0]),
        .pop(post_rx), .rd_idx(rx_done), .rd_addr(rx_rd_addr), .rd_count(rx_rd_count),
        .head_addr(rx_hd_addr), .head_count(rx_hd_count), .level(rx_level), .full(rx_full)
    );

    // input header: grant on request, host clears ready to hand the command over
    always_ff @(posedge mclk)
    begin
        if (srst || init_cmd)
        begin
            {in_type, in_rx, in_req, in_iei, in_rdy} <= '0;
        end
        else if (reg_wr && reg_addr == lccp_pkg::REG_HDR_IN)
        begin
            in_type <= reg_wdata[lccp_pkg::HI_TYPE_LSB +: 2];
            in_rx <= reg_wdata[lccp_pkg::HI_RX];
            in_req <= reg_wdata[lccp_pkg::HI_REQ];
            in_iei <= reg_wdata[lccp_pkg::HI_IEI];
            in_rdy <= in_rdy && reg_wdata[lccp_pkg::HI_RDY];
        end
        else if (in_req && !in_rdy)
            in_rdy <= 1'b1; // see RULE3
    end

    // output header: device raises ready on the same edge that loads the data words
    always_ff @(posedge mclk)
    begin
        if (srst || init_cmd)
            {out_type, out_rx, out_ieo, out_rdy} <= '0;
        else if (post_err || post_rx || post_tx)
        begin
            out_type <= post_err ? lccp_pkg::CMD_CTL_OUT : lccp_pkg::CMD_BUF_OUT;
            out_rx <= post_rx;
            out_rdy <= 1'b1; // see RULE4
        end
        else if (reg_wr && reg_addr == lccp_pkg::REG_HDR_OUT)
        begin
            out_ieo <= reg_wdata[lccp_pkg::HO_IEO];
            out_rdy <= out_rdy && reg_wdata[lccp_pkg::HO_RDY];
        end
    end

    // data port shared by both directions
    always_ff @(posedge mclk)
    begin
        if (srst || init_cmd)
            {data0, data1} <= '0;
        else if (post_err)
        begin
            data0 <= {8'h00, err_code};
            data1 <= 16'(err_fatal) << lccp_pkg::D1_FATAL; // see RULE17
        end
        else if (post_rx)
        begin
            data0 <= rx_hd_addr[15:0];
            data1 <= {rx_hd_addr[17:16], rx_hd_count};
        end
        else if (post_tx)
        begin
            data0 <= tx_hd_addr[15:0];
            data1 <= {tx_hd_addr[17:16], tx_hd_count};
        end
        else if (reg_wr && reg_addr == lccp_pkg::REG_DATA0)
            data0 <= reg_wdata;
        else if (reg_wr && reg_addr == lccp_pkg::REG_DATA1)
            data1 <= reg_wdata;
    end

    // read data one cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (srst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                lccp_pkg::REG_HDR_IN: reg_rdata <= {8'h00, in_rdy, in_iei, in_req,
                    2'h0, in_rx, in_type};
                lccp_pkg::REG_HDR_OUT: reg_rdata <= {8'h00, out_rdy, out_ieo, 3'h0,
                    out_rx, out_type};
                lccp_pkg::REG_DATA0: reg_rdata <= data0;
                default: reg_rdata <= data1; // see RULE1
            endcase
        end
    end

    // operating state and executed input commands
    always_ff @(posedge mclk)
    begin
        link_start <= 1'b0;
        if (srst)
        begin
            state <= lccp_pkg::LCCP_UNINIT;
            {base_addr, link_half_duplex, link_maint, link_running} <= '0;
        end
        else if (init_cmd)
        begin
            state <= lccp_pkg::LCCP_WAIT_BASE; // see RULE6
            {base_addr, link_half_duplex, link_maint, link_running} <= '0;
        end
        else
        begin
            case (state)
                lccp_pkg::LCCP_WAIT_BASE:
                    if (issue && in_type == lccp_pkg::CMD_BASE_IN) // see RULE10
                    begin
                        base_addr <= cmd_addr; // see RULE8
                        state <= lccp_pkg::LCCP_RUN;
                        link_start <= !data1[lccp_pkg::D1_RESUME]; // see RULE11
                        link_running <= 1'b1;
                    end
                lccp_pkg::LCCP_RUN:
                    if (link_fatal)
                    begin
                        state <= lccp_pkg::LCCP_DUMP; // see RULE9
                        link_running <= 1'b0; // see RULE17
                    end
                    else if (issue && in_type == lccp_pkg::CMD_CTL_IN) // see RULE13
                    begin
                        link_half_duplex <= data1[lccp_pkg::D1_HALF]; // see RULE12
                        link_maint <= data1[lccp_pkg::D1_MAINT];
                    end
                lccp_pkg::LCCP_DUMP:
                    if (dma_st == lccp_pkg::LCCP_D_SNAP && dma_done
                        && snap_off == lccp_pkg::SNAP_WORDS - 13'h1)
                        state <= lccp_pkg::LCCP_HALT; // see RULE7
                default: state <= state;
            endcase
        end
    end

    // pending error report; a newer event wins over the clear by posting
    always_ff @(posedge mclk)
    begin
        if (srst || init_cmd)
            {err_pend, err_fatal, err_code} <= '0;
        else if (state == lccp_pkg::LCCP_RUN && link_fatal)
            {err_pend, err_fatal, err_code} <= {2'b11, link_err_code};
        else if (overflow)
            {err_pend, err_fatal, err_code} <= {2'b10, lccp_pkg::ERR_OVERFLOW};
        else if (state == lccp_pkg::LCCP_RUN && link_error && !err_fatal)
            {err_pend, err_fatal, err_code} <= {2'b10, link_err_code};
        else if (post_err)
            err_pend <= 1'b0;
    end

    // count of completed buffers awaiting return
    always_ff @(posedge mclk)
    begin
        if (srst || init_cmd)
            {tx_done, rx_done} <= '0;
        else
        begin
            tx_done <= tx_done + 3'(tx_ack && tx_wait) - 3'(post_tx); // see RULE16
            rx_done <= rx_done + 3'(rx_good) - 3'(post_rx);
        end
    end

    // transmit sequencing and retransmission
    always_ff @(posedge mclk)
    begin
        if (srst || init_cmd)
        begin
            tx_wait <= 1'b0;
            tx_seq <= lccp_pkg::SEQ_INIT;
        end
        else if (dma_st == lccp_pkg::LCCP_D_TX && tx_off == tx_words && !dma_req)
            tx_wait <= 1'b1;
        else if (tx_wait && tx_ack)
        begin
            tx_wait <= 1'b0;
            tx_seq <= tx_seq + 8'h01; // see RULE19
        end
        else if (tx_wait && tx_nak)
            tx_wait <= 1'b0; // see RULE18
    end

    // receive sequence expectation and nak on a bad check
    always_ff @(posedge mclk)
    begin
        rx_nak <= 1'b0;
        if (srst || init_cmd)
            rx_expect <= lccp_pkg::SEQ_INIT;
        else if (rx_good)
            rx_expect <= rx_expect + 8'h01; // see RULE19
        else if (rx_ready && rx_end && rx_run_crc != rx_crc)
            rx_nak <= 1'b1; // see RULE18
    end

    // memory request engine: snapshot, then receive, then transmit
    always_ff @(posedge mclk)
    begin
        tx_word_valid <= 1'b0;
        tx_end <= 1'b0;
        if (srst || init_cmd)
        begin
            dma_st <= lccp_pkg::LCCP_D_IDLE;
            {dma_req, dma_write, dma_addr, dma_wdata, rx_ready} <= '0;
            {tx_word, tx_crc, tx_off, tx_words, rx_off, snap_off} <= '0;
            tx_run_crc <= lccp_pkg::CRC_INIT;
            rx_run_crc <= lccp_pkg::CRC_INIT;
        end
        else
        begin
            case (dma_st)
                lccp_pkg::LCCP_D_IDLE:
                    if (state == lccp_pkg::LCCP_DUMP)
                    begin
                        rx_ready <= 1'b0;
                        dma_st <= lccp_pkg::LCCP_D_SNAP;
                        snap_off <= '0;
                    end
                    else if (rx_ready && rx_end)
                    begin
                        // good, bad or duplicate: next frame starts at offset zero
                        rx_off <= '0;
                        rx_run_crc <= lccp_pkg::CRC_INIT;
                        rx_ready <= 1'b0;
                    end
                    else if (rx_ready && rx_word_valid)
                    begin
                        rx_ready <= 1'b0;
                        rx_run_crc <= lccp_pkg::crc16_word(rx_run_crc, rx_word);
                        rx_off <= rx_off + 13'h1;
                        if ({rx_off, 1'b0} < {1'b0, rx_rd_count})
                        begin
                            dma_st <= lccp_pkg::LCCP_D_RX;
                            dma_req <= 1'b1; // see RULE5
                            dma_write <= 1'b1;
                            dma_addr <= word_addr(rx_rd_addr, rx_off);
                            dma_wdata <= rx_word;
                        end
                    end
                    else if (state == lccp_pkg::LCCP_RUN && !tx_wait
                             && tx_done < tx_level)
                    begin
                        dma_st <= lccp_pkg::LCCP_D_TX;
                        rx_ready <= 1'b0;
                        tx_off <= '0;
                        tx_words <= 13'(({1'b0, tx_rd_count} + 15'h1) >> 1);
                        tx_run_crc <= lccp_pkg::CRC_INIT;
                    end
                    else
                        rx_ready <= state == lccp_pkg::LCCP_RUN
                                    && rx_done < rx_level; // see RULE21
                lccp_pkg::LCCP_D_RX:
                    if (dma_done)
                    begin
                        dma_req <= 1'b0;
                        dma_st <= lccp_pkg::LCCP_D_IDLE;
                    end
                lccp_pkg::LCCP_D_TX:
                    if (dma_req)
                    begin
                        if (dma_done)
                        begin
                            dma_req <= 1'b0;
                            tx_word <= dma_rdata;
                            tx_word_valid <= 1'b1;
                            tx_run_crc <= lccp_pkg::crc16_word(tx_run_crc, dma_rdata);
                            tx_off <= tx_off + 13'h1;
                        end
                    end
                    else if (tx_off == tx_words)
                    begin
                        tx_end <= 1'b1;
                        tx_crc <= tx_run_crc; // see RULE18
                        dma_st <= lccp_pkg::LCCP_D_IDLE;
                    end
                    else
                    begin
                        dma_req <= 1'b1;
                        dma_write <= 1'b0;
                        dma_addr <= word_addr(tx_rd_addr, tx_off);
                    end
                lccp_pkg::LCCP_D_SNAP:
                    if (!dma_req)
                    begin
                        dma_req <= 1'b1;
                        dma_write <= 1'b1;
                        dma_addr <= word_addr(base_addr, snap_off); // see RULE9
                        dma_wdata <= snap_data;
                    end
                    else if (dma_done)
                    begin
                        dma_req <= 1'b0;
                        snap_off <= snap_off + 13'h1;
                        if (snap_off == lccp_pkg::SNAP_WORDS - 13'h1)
                            dma_st <= lccp_pkg::LCCP_D_IDLE;
                    end
                default: dma_st <= lccp_pkg::LCCP_D_IDLE;
            endcase
        end
    end
endmodule // lccp_cmd_port

// [test/lccp_cmd_port_asserts.sv]
// protocol checks on the command port pins
module lccp_cmd_port_asserts (
    input wire logic mclk,
    input wire logic srst,
    input wire logic dma_req,
    input wire logic dma_done,
    input wire logic tx_word_valid,
    input wire logic tx_end,
    input wire logic rx_ready,
    input wire logic rx_word_valid,
    input wire logic rx_end,
    input wire logic rx_nak,
    input wire logic link_start,
    input wire logic link_running,
    input wire logic link_fatal
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_req_held: assert property (dma_req && !dma_done |=> dma_req) else $error("req dropped");
    a_word_after_dma: assert property (tx_word_valid |-> $past(dma_done)) else $error("word early");
    a_rx_pause: assert property (rx_ready && (rx_word_valid || rx_end) |=> !rx_ready) else $error("rx");
    a_nak_cause: assert property (rx_nak |-> $past(rx_end)) else $error("nak without end");
    a_nak_pulse: assert property (rx_nak |=> !rx_nak) else $error("nak too long");
    a_start_pulse: assert property (link_start |=> !link_start) else $error("start too long");
    a_fatal_stop: assert property (link_fatal |=> !link_running) else $error("still running");
    a_end_waits: assert property (tx_end |=> !tx_end) else $error("end repeated");
endmodule // lccp_cmd_port_asserts

bind lccp_cmd_port lccp_cmd_port_asserts u_chk (.*);

// [test/lccp_host_mem.sv]
// host memory, one request at a time
module lccp_host_mem (
    input wire logic mclk,
    input wire logic srst,
    input wire logic dma_req,
    input wire logic dma_write,
    input wire logic [17:0] dma_addr,
    input wire logic slow,
    output logic dma_done,
    output logic [15:0] dma_rdata,
    output logic [7:0] n_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    // idle read data toggles so a stale sample never looks right
    always_ff @(posedge mclk)
    begin
        dma_done <= 1'b0;
        dma_rdata <= ~dma_rdata;
        if (srst)
        begin
            wait_cnt <= 2'h0;
            n_wr <= 8'h00;
            dma_rdata <= 16'h0000;
        end
        else if (dma_req && !dma_done)
        begin
            wait_cnt <= wait_cnt + 2'h1;
            if (!slow || wait_cnt == 2'h3)
            begin
                dma_done <= 1'b1;
                dma_rdata <= dma_addr[15:0] ^ 16'h5a5a;
                n_wr <= n_wr + {7'h00, dma_write}; // counts every completed write
            end
        end
    end
endmodule // lccp_host_mem

// [test/link_controller_command_port_tb.sv]
module link_controller_command_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, srst, reg_wr, reg_rd, dma_done, tx_ack, tx_nak, rx_end, link_fatal, slow;
    logic dma_req, dma_write, tx_word_valid, tx_end, rx_ready, rx_nak, link_start;
    logic link_half_duplex, link_maint, link_running;
    logic [1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, dma_rdata, tx_word, rx_crc;
    logic [17:0] dma_addr;
    logic [7:0] n_wr;
    int error_cnt = 0;
    int n_compared = 0;
    lccp_cmd_port u_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req),
        .dma_write(dma_write), .dma_addr(dma_addr), .dma_wdata(), .dma_done(dma_done),
        .dma_rdata(dma_rdata), .tx_word_valid(tx_word_valid), .tx_word(tx_word), .tx_seq(),
        .tx_end(tx_end), .tx_crc(), .tx_ack(tx_ack), .tx_nak(tx_nak), .rx_ready(rx_ready),
        .rx_word_valid(1'b0), .rx_word(16'h0000), .rx_end(rx_end), .rx_crc(rx_crc),
        .rx_seq(8'h00), .rx_nak(rx_nak), .link_start(link_start),
        .link_half_duplex(link_half_duplex), .link_maint(link_maint),
        .link_running(link_running), .link_fatal(link_fatal), .link_error(1'b0),
        .link_err_code(8'h00));
    lccp_host_mem u_mem (.*);
    // 200 mhz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic wrap_up;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // pulses are one cycle, so look just after every edge
    task automatic wait_hi(ref logic s, input int n);
        repeat (n)
        begin
            #1;
            if (s === 1'b1)
                break;
            @(posedge mclk);
        end
        chk({15'h0000, s}, 16'h0001);
    endtask
    // request, see grant, load data, release to execute
    task automatic cmd(input logic [15:0] h, input logic [15:0] d0, input logic [15:0] d1);
        wr(2'h0, 16'h0020 | h);
        @(posedge mclk);
        rd(2'h0, 16'h00a0 | h);
        wr(2'h2, d0);
        wr(2'h3, d1);
        wr(2'h0, h);
    endtask
    // watchdog, far past the run
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        {reg_wr, reg_rd, tx_ack, tx_nak, rx_end, link_fatal, slow} = 7'h00;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        rx_crc = 16'hffff;
        srst = 1'b1;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        rd(2'h1, 16'h0000);
        wr(2'h0, 16'h8000);
        cmd(16'h0003, 16'h1000, 16'h0000);
        wait_hi(link_start, 4);
        cmd(16'h0001, 16'h0000, 16'h0002);
        @(posedge mclk);
        #1 chk({14'h0000, link_half_duplex, link_maint}, 16'h0002);
        cmd(16'h0001, 16'h0000, 16'h0001);
        @(posedge mclk);
        #1 chk({14'h0000, link_half_duplex, link_maint}, 16'h0001);
        // eight transmit buffers, the first sent at once, the last refused
        for (int i = 0; i < 8; i++)
        begin
            cmd(16'h0000, 16'h0100 + 16'(i * 16), 16'h0002);
            if (i == 0)
            begin
                wait_hi(tx_word_valid, 20);
                chk(tx_word, 16'h5b5a);
                wait_hi(tx_end, 20);
            end
        end
        rd(2'h1, 16'h0081);
        rd(2'h2, 16'h0001);
        rd(2'h3, 16'h0000);
        wr(2'h1, 16'h0000);
        @(posedge mclk);
        tx_ack <= 1'b1;
        @(posedge mclk);
        tx_ack <= 1'b0;
        rd(2'h1, 16'h0080);
        rd(2'h2, 16'h0100);
        wr(2'h1, 16'h0000);
        // receive frame with a bad check value
        cmd(16'h0004, 16'h0800, 16'h0004);
        wait_hi(rx_ready, 10);
        @(posedge mclk);
        rx_end <= 1'b1;
        @(posedge mclk);
        rx_end <= 1'b0;
        wait_hi(rx_nak, 4);
        chk({8'h00, n_wr}, 16'h0000);
        @(posedge mclk);
        slow <= 1'b1;
        link_fatal <= 1'b1;
        @(posedge mclk);
        link_fatal <= 1'b0;
        repeat (2000)
        begin
            @(posedge mclk);
            if (n_wr === 8'h80)
                break;
        end
        chk({8'h00, n_wr}, 16'h0080);
        rd(2'h1, 16'h0081);
        rd(2'h3, 16'h8000);
        wr(2'h0, 16'h8000);
        rd(2'h1, 16'h0000);
        wrap_up();
    end
endmodule // link_controller_command_port_tb
